// File: src/vme_mode_bank.sv
// Mode-control register bank of the video encoder with its serial port.
//
// Functional notes
// - DAC output bit set routes composite, luma, chroma to DACs A to C.
// - Both selects clear put component on A to C, composite set on D to F.
// - SCART set alone gives composite, component split and luma/chroma.
// - Pedestal goes on NTSC composite only, never under PAL.
// - Square pixel only in slave timing and never with oversampling.
// - Standard comes from register when source bit set, else from pin.
// - Pixel valid resets clear; clear blanks pixels and forces master timing.
// - Sleep bit enters sleep; clearing it or reset leaves sleep.
// - Sleep bit counts only with power-up control clear; else pins decide.
// - Two low bits of register 03 read a fixed revision code.
// - Blanking interval data passes or is blanked, also in slave mode 0.
// - Teletext inserted only when enabled; request level or per-bit.
// - Long vertical sync lasts three NTSC or 2.5 PAL lines.
// - Genlock code 0 ignores pin; code 3 makes pin real-time control.
// - Genlock timing reset holds counters while pin is high.
// - Subcarrier reset on pin rising edge, applied at next field start.
// - Active line 720 pixels, or 710 NTSC and 702 PAL.
// - Chroma and burst bits switch colour and burst on outputs.
// - Colour bars generate test pattern and force master timing.
// - UV level selects amplitude; Y level selects SMPTE levels.
// - Clamp shift 0 to 3 cycles, direction and porch from register.
// - Subaddress byte then auto-increment on each data byte; reads hold at register 05, writes past it are not acknowledged.
`timescale 1ns/1ps
module vme_mode_bank (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe_n,
  input wire logic addr_lsb_pin,
  input wire logic standard_select_pin,
  input wire logic genlock_pin,
  input wire logic teletext_input_pin,
  input wire logic output_standard_low_bit,
  input wire logic slave_timing_mode,
  input wire logic oversample_4x,
  input wire logic power_up_sleep_control,
  input wire logic field_start,
  input wire logic teletext_bit_request,
  output vme_pkg::vme_dac_src_t dac_a_src,
  output vme_pkg::vme_dac_src_t dac_b_src,
  output vme_pkg::vme_dac_src_t dac_c_src,
  output vme_pkg::vme_dac_src_t dac_d_src,
  output vme_pkg::vme_dac_src_t dac_e_src,
  output vme_pkg::vme_dac_src_t dac_f_src,
  output logic component_yuv,
  output logic std_pal,
  output logic pedestal_active,
  output logic square_pixel_active,
  output logic pixel_blank,
  output logic force_master_timing,
  output logic sleep_active,
  output logic blanking_interval_pass,
  output logic teletext_insert,
  output logic teletext_request,
  output logic long_vertical_sync,
  output logic [3:0] vsync_half_lines,
  output logic timing_hold,
  output logic subcarrier_reset,
  output logic rtc_enable,
  output logic rtc_data,
  output logic [9:0] active_line_pixels,
  output logic chroma_on,
  output logic burst_on,
  output logic color_bars_on,
  output logic interlace_ctl,
  output logic [1:0] cc_field_select,
  output logic y_smpte_levels,
  output logic [9:0] uv_amp_mv,
  output logic rgb_sync_on,
  output logic [1:0] clamp_shift,
  output logic clamp_negative,
  output logic clamp_back_porch
);
  // ==========================================================
  // Pin synchronisers
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_meta_q, pin_sync_q;
  logic gl_prev_q, sda_out_q;
  logic scl_s, sda_s, alsb_s, std_s, gl_s, tt_s;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta_q <= vme_pkg::PIN_IDLE;
      pin_sync_q <= vme_pkg::PIN_IDLE;
      gl_prev_q <= 1'b0;
      sda_out_q <= 1'b0;
    end else if (clk_en) begin
      pin_meta_q <= {teletext_input_pin, genlock_pin, standard_select_pin,
                     addr_lsb_pin, sda_pin_in, scl_pin};
      pin_sync_q <= pin_meta_q;
      gl_prev_q <= gl_s;
      sda_out_q <= 1'b0;
    end
  end
  assign {tt_s, gl_s, std_s, alsb_s, sda_s, scl_s} = pin_sync_q;

  // ==========================================================
  // Serial port
  logic [7:0] reg_addr, wr_data, rd_data;
  logic wr_pulse, oe_n;

  vme_serial_slave u_port (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .addr_sel(alsb_s),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_pulse(wr_pulse),
    .wr_data(wr_data),
    .sda_oe_n(oe_n)
  );
  assign sda_pin_out = sda_out_q;
  assign sda_pin_oe_n = oe_n;

  // ==========================================================
  // Registers
  logic [7:0] rt_q, rt_d, vb_q, vb_d, sg_q, sg_d, lc_q, lc_d;
  logic sch_pend_q, sch_pend_d;
  vme_pkg::vme_out_t out_q, out_d;

  always_comb begin
    rt_d = rt_q;
    vb_d = vb_q;
    sg_d = sg_q;
    lc_d = lc_q;
    if (wr_pulse) begin
      case (reg_addr)
        vme_pkg::RT_ADDR: rt_d = wr_data;
        vme_pkg::VB_ADDR: vb_d = {wr_data[7:2], vme_pkg::REV_CODE};
        vme_pkg::SG_ADDR: sg_d = wr_data;
        vme_pkg::LC_ADDR: lc_d = wr_data;
        default: rt_d = rt_q;
      endcase
    end
  end

  always_comb begin
    case (reg_addr)
      vme_pkg::RT_ADDR: rd_data = rt_q;
      vme_pkg::VB_ADDR: rd_data = {vb_q[7:2], vme_pkg::REV_CODE};
      vme_pkg::SG_ADDR: rd_data = sg_q;
      vme_pkg::LC_ADDR: rd_data = lc_q;
      default: rd_data = '0;
    endcase
  end

  // ==========================================================
  // Derived controls
  logic pal, yuv, pdv, cbar, gl_rise;
  logic [1:0] gl_mode, uv_sel;

  always_comb begin
    out_d = out_q;
    yuv = rt_q[vme_pkg::B_RGB_YUV];
    pdv = rt_q[vme_pkg::B_PDV];
    cbar = sg_q[vme_pkg::B_CBAR];
    gl_mode = sg_q[vme_pkg::B_GL_LO +: 2];
    uv_sel = lc_q[vme_pkg::B_UV_LO +: 2];
    gl_rise = gl_s && !gl_prev_q;
    // standard from register or from pin.
    pal = rt_q[vme_pkg::B_SRC] ? output_standard_low_bit : std_s;
    out_d.std_pal = pal;
    out_d.component_yuv = yuv;
    // routing with DAC output bit set.
    if (rt_q[vme_pkg::B_DAC_OUT]) begin
      out_d.dac_a = vme_pkg::VME_CVBS;
      out_d.dac_b = vme_pkg::VME_LUMA;
      out_d.dac_c = vme_pkg::VME_CHROMA;
      out_d.dac_d = vme_pkg::VME_G_Y;
      out_d.dac_e = vme_pkg::VME_B_U;
      out_d.dac_f = vme_pkg::VME_R_V;
    end else if (rt_q[vme_pkg::B_SCART]) begin
      out_d.dac_a = vme_pkg::VME_CVBS;
      out_d.dac_b = vme_pkg::VME_B_U;
      out_d.dac_c = vme_pkg::VME_R_V;
      out_d.dac_d = vme_pkg::VME_G_Y;
      out_d.dac_e = vme_pkg::VME_LUMA;
      out_d.dac_f = vme_pkg::VME_CHROMA;
    end else begin
      out_d.dac_a = vme_pkg::VME_G_Y;
      out_d.dac_b = vme_pkg::VME_B_U;
      out_d.dac_c = vme_pkg::VME_R_V;
      out_d.dac_d = vme_pkg::VME_CVBS;
      out_d.dac_e = vme_pkg::VME_LUMA;
      out_d.dac_f = vme_pkg::VME_CHROMA;
    end
    out_d.pedestal_active = rt_q[vme_pkg::B_PED] && !pal;
    out_d.square_pixel_active = rt_q[vme_pkg::B_SQ] && slave_timing_mode
                                && !oversample_4x;
    // blanking and master timing until pixels are valid.
    out_d.pixel_blank = !pdv;
    // colour bars also force master timing.
    out_d.force_master_timing = !pdv || cbar;
    out_d.color_bars_on = cbar;
    out_d.sleep_active = power_up_sleep_control ? (std_s && gl_s)
                         : rt_q[vme_pkg::B_SLEEP];
    out_d.blanking_interval_pass = vb_q[vme_pkg::B_VBI];
    out_d.teletext_insert = vb_q[vme_pkg::B_TT_EN] && tt_s;
    out_d.teletext_request = vb_q[vme_pkg::B_TT_EN]
      && (!vb_q[vme_pkg::B_TT_REQ] || teletext_bit_request);
    out_d.cc_field_select = vb_q[vme_pkg::B_CC_LO +: 2];
    out_d.long_vertical_sync = sg_q[vme_pkg::B_VS3];
    out_d.vsync_half_lines = pal ? vme_pkg::VS_HALF_PAL
                             : vme_pkg::VS_HALF_NTSC;
    // genlock pin off or real-time control.
    out_d.rtc_enable = (gl_mode == vme_pkg::GL_RTC);
    out_d.rtc_data = (gl_mode == vme_pkg::GL_RTC) && gl_s;
    // timing counters held while the pin is high.
    out_d.timing_hold = (gl_mode == vme_pkg::GL_TRESET) && gl_s;
    // subcarrier reset waits for the next field start.
    sch_pend_d = sch_pend_q;
    out_d.subcarrier_reset = field_start && sch_pend_q;
    if (field_start) begin
      sch_pend_d = 1'b0;
    end
    if (gl_mode == vme_pkg::GL_SCRESET && gl_rise) begin
      sch_pend_d = 1'b1;
    end
    if (!sg_q[vme_pkg::B_ALINE]) begin
      out_d.active_line_pixels = vme_pkg::PIX_601;
    end else begin
      out_d.active_line_pixels = pal ? vme_pkg::PIX_PAL_470
                                 : vme_pkg::PIX_NTSC_470;
    end
    out_d.chroma_on = sg_q[vme_pkg::B_CHROMA];
    out_d.burst_on = sg_q[vme_pkg::B_BURST];
    out_d.interlace_ctl = sg_q[vme_pkg::B_INTERL];
    out_d.y_smpte_levels = lc_q[vme_pkg::B_YLVL];
    case (uv_sel)
      vme_pkg::UV_700: out_d.uv_amp_mv = vme_pkg::MV_700;
      vme_pkg::UV_1000: out_d.uv_amp_mv = vme_pkg::MV_1000;
      default: out_d.uv_amp_mv = pal ? vme_pkg::MV_700 : vme_pkg::MV_934;
    endcase
    out_d.rgb_sync_on = lc_q[vme_pkg::B_RGBSYNC];
    out_d.clamp_shift = lc_q[vme_pkg::B_CLDLY_LO +: 2];
    out_d.clamp_negative = lc_q[vme_pkg::B_CLDIR];
    out_d.clamp_back_porch = lc_q[vme_pkg::B_CLPOS];
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      // pixel valid and sleep reset clear.
      rt_q <= vme_pkg::REG_RESET;
      vb_q <= vme_pkg::REG_RESET;
      sg_q <= vme_pkg::REG_RESET;
      lc_q <= vme_pkg::REG_RESET;
      sch_pend_q <= 1'b0;
      out_q <= '0;
    end else if (clk_en) begin
      rt_q <= rt_d;
      vb_q <= vb_d;
      sg_q <= sg_d;
      lc_q <= lc_d;
      sch_pend_q <= sch_pend_d;
      out_q <= out_d;
    end
  end

  assign {dac_a_src, dac_b_src, dac_c_src} = {out_q.dac_a, out_q.dac_b,
                                              out_q.dac_c};
  assign {dac_d_src, dac_e_src, dac_f_src} = {out_q.dac_d, out_q.dac_e,
                                              out_q.dac_f};
  assign component_yuv = out_q.component_yuv;
  assign std_pal = out_q.std_pal;
  assign pedestal_active = out_q.pedestal_active;
  assign square_pixel_active = out_q.square_pixel_active;
  assign pixel_blank = out_q.pixel_blank;
  assign force_master_timing = out_q.force_master_timing;
  assign sleep_active = out_q.sleep_active;
  assign blanking_interval_pass = out_q.blanking_interval_pass;
  assign teletext_insert = out_q.teletext_insert;
  assign teletext_request = out_q.teletext_request;
  assign long_vertical_sync = out_q.long_vertical_sync;
  assign vsync_half_lines = out_q.vsync_half_lines;
  assign timing_hold = out_q.timing_hold;
  assign subcarrier_reset = out_q.subcarrier_reset;
  assign rtc_enable = out_q.rtc_enable;
  assign rtc_data = out_q.rtc_data;
  assign active_line_pixels = out_q.active_line_pixels;
  assign chroma_on = out_q.chroma_on;
  assign burst_on = out_q.burst_on;
  assign color_bars_on = out_q.color_bars_on;
  assign interlace_ctl = out_q.interlace_ctl;
  assign cc_field_select = out_q.cc_field_select;
  assign y_smpte_levels = out_q.y_smpte_levels;
  assign uv_amp_mv = out_q.uv_amp_mv;
  assign rgb_sync_on = out_q.rgb_sync_on;
  assign clamp_shift = out_q.clamp_shift;
  assign clamp_negative = out_q.clamp_negative;
  assign clamp_back_porch = out_q.clamp_back_porch;

  // ==========================================================
  // Checks
  a_dac_route: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && rt_q[vme_pkg::B_DAC_OUT] |=> dac_a_src == vme_pkg::VME_CVBS
    && dac_c_src == vme_pkg::VME_CHROMA) else $error("dac route wrong");
  a_scart_route: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && rt_q[vme_pkg::B_SCART] && !rt_q[vme_pkg::B_DAC_OUT]
    |=> dac_a_src == vme_pkg::VME_CVBS && dac_d_src == vme_pkg::VME_G_Y)
    else $error("scart route wrong");
  a_pedestal_pal: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    std_pal |-> !pedestal_active) else $error("pedestal under pal");
  a_square_gate: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && oversample_4x |=> !square_pixel_active)
    else $error("square pixel with oversampling");
  a_pixel_blank: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && !pdv |=> pixel_blank && force_master_timing)
    else $error("pixels not blanked");
  a_sleep_bit: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && !power_up_sleep_control |=>
    sleep_active == $past(rt_q[vme_pkg::B_SLEEP])) else $error("sleep");
  a_rev_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    reg_addr == vme_pkg::VB_ADDR |-> rd_data[1:0] == vme_pkg::REV_CODE)
    else $error("revision code lost");
  a_timing_hold: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && gl_mode == vme_pkg::GL_TRESET && gl_s |=> timing_hold)
    else $error("counters not held");
  a_line_len: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && !sg_q[vme_pkg::B_ALINE] |=>
    active_line_pixels == vme_pkg::PIX_601) else $error("line length");
  a_uv_level: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    clk_en && uv_sel == vme_pkg::UV_1000 |=> uv_amp_mv == vme_pkg::MV_1000)
    else $error("uv level wrong");
endmodule

// File: shared/vme_pkg.sv
// Package with the mode-bank register map, field layout and output group.
package vme_pkg;
  // ==========================================================
  // Register subaddresses
  localparam logic [7:0] RT_ADDR = 8'h02;
  localparam logic [7:0] VB_ADDR = 8'h03;
  localparam logic [7:0] SG_ADDR = 8'h04;
  localparam logic [7:0] LC_ADDR = 8'h05;
  localparam logic [7:0] SUB_FIRST = RT_ADDR;
  localparam logic [7:0] SUB_LAST = LC_ADDR;
  localparam logic [7:0] SUB_STEP = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Revision code value is arbitrary.
  localparam logic [1:0] REV_CODE = 2'h1;
  // Slave address base value is arbitrary; bit 1 comes from a pin.
  localparam logic [6:0] SLAVE_BASE = 7'h2a;
  localparam int SLAVE_PIN_BIT = 1;
  // Idle level of the synchronised pins: serial clock and data high.
  localparam logic [5:0] PIN_IDLE = 6'h03;
  // ==========================================================
  // Field positions
  localparam int B_RGB_YUV = 0;
  localparam int B_DAC_OUT = 1;
  localparam int B_SCART = 2;
  localparam int B_PED = 3;
  localparam int B_SQ = 4;
  localparam int B_SRC = 5;
  localparam int B_PDV = 6;
  localparam int B_SLEEP = 7;
  localparam int B_VBI = 2;
  localparam int B_TT_EN = 3;
  localparam int B_TT_REQ = 4;
  localparam int B_CC_LO = 5;
  localparam int B_VS3 = 0;
  localparam int B_GL_LO = 1;
  localparam int B_ALINE = 3;
  localparam int B_CHROMA = 4;
  localparam int B_BURST = 5;
  localparam int B_CBAR = 6;
  localparam int B_INTERL = 7;
  localparam int B_YLVL = 0;
  localparam int B_UV_LO = 1;
  localparam int B_RGBSYNC = 3;
  localparam int B_CLDLY_LO = 4;
  localparam int B_CLDIR = 6;
  localparam int B_CLPOS = 7;
  // ==========================================================
  // Field codes and output values
  localparam logic [1:0] GL_OFF = 2'h0;
  localparam logic [1:0] GL_SCRESET = 2'h1;
  localparam logic [1:0] GL_TRESET = 2'h2;
  localparam logic [1:0] GL_RTC = 2'h3;
  localparam logic [1:0] UV_DEFAULT = 2'h0;
  localparam logic [1:0] UV_700 = 2'h1;
  localparam logic [1:0] UV_1000 = 2'h2;
  localparam logic [9:0] MV_700 = 10'h2bc;
  localparam logic [9:0] MV_934 = 10'h3a6;
  localparam logic [9:0] MV_1000 = 10'h3e8;
  localparam logic [9:0] PIX_601 = 10'h2d0;
  localparam logic [9:0] PIX_NTSC_470 = 10'h2c6;
  localparam logic [9:0] PIX_PAL_470 = 10'h2be;
  localparam logic [3:0] VS_HALF_NTSC = 4'h6;
  localparam logic [3:0] VS_HALF_PAL = 4'h5;
  localparam logic [3:0] BITS_LAST = 4'h7;
  localparam logic [3:0] BITS_FULL = 4'h8;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    VME_CVBS, VME_LUMA, VME_CHROMA, VME_G_Y, VME_B_U, VME_R_V
  } vme_dac_src_t;
  typedef struct packed {
    vme_dac_src_t dac_a, dac_b, dac_c, dac_d, dac_e, dac_f;
    logic component_yuv, std_pal, pedestal_active, square_pixel_active;
    logic pixel_blank, force_master_timing, sleep_active;
    logic blanking_interval_pass, teletext_insert, teletext_request;
    logic long_vertical_sync;
    logic [3:0] vsync_half_lines;
    logic timing_hold, subcarrier_reset, rtc_enable, rtc_data;
    logic [9:0] active_line_pixels;
    logic chroma_on, burst_on, color_bars_on, interlace_ctl;
    logic [1:0] cc_field_select;
    logic y_smpte_levels;
    logic [9:0] uv_amp_mv;
    logic rgb_sync_on;
    logic [1:0] clamp_shift;
    logic clamp_negative, clamp_back_porch;
  } vme_out_t;
  // ==========================================================
  // Subaddress inside the bank.
  function automatic logic sub_valid(input logic [7:0] a);
    return (a >= SUB_FIRST) && (a <= SUB_LAST);
  endfunction
endpackage

// File: src/vme_serial_slave.sv
// Two-wire serial slave that moves bytes between the host and the bank.
`timescale 1ns/1ps
module vme_serial_slave (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic addr_sel,
  input wire logic [7:0] rd_data,
  output logic [7:0] reg_addr,
  output logic wr_pulse,
  output logic [7:0] wr_data,
  output logic sda_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_SUB, ST_WR, ST_ACK, ST_RD, ST_MACK
  } vme_ser_state_t;

  vme_ser_state_t st_q, st_d, nx_q, nx_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, wd_q, wd_d;
  logic oe_n_q, oe_n_d, wr_q, wr_d, scl_p_q, sda_p_q;
  logic start, stop, rise, fall;
  logic [6:0] dev_addr;

  assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign rise = scl_s && !scl_p_q;
  assign fall = !scl_s && scl_p_q;
  always_comb begin
    dev_addr = vme_pkg::SLAVE_BASE;
    dev_addr[vme_pkg::SLAVE_PIN_BIT] = addr_sel;
  end

  // ==========================================================
  // Byte engine
  always_comb begin
    st_d = st_q;
    nx_d = nx_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    wd_d = wd_q;
    oe_n_d = oe_n_q;
    wr_d = 1'b0;
    if (start) begin
      st_d = ST_DEV;
      cnt_d = '0;
      oe_n_d = 1'b1;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        ST_DEV, ST_SUB, ST_WR: begin
          if (rise && cnt_q != vme_pkg::BITS_FULL) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = 4'(cnt_q + 4'h1);
          end else if (fall && cnt_q == vme_pkg::BITS_FULL) begin
            cnt_d = '0;
            st_d = ST_IDLE;
            if (st_q == ST_DEV && sh_q[7:1] == dev_addr) begin
              oe_n_d = 1'b0;
              st_d = ST_ACK;
              nx_d = sh_q[0] ? ST_RD : ST_SUB;
            end else if (st_q == ST_SUB && vme_pkg::sub_valid(sh_q)) begin
              oe_n_d = 1'b0;
              st_d = ST_ACK;
              nx_d = ST_WR;
              ptr_d = sh_q;
            end else if (st_q == ST_WR && vme_pkg::sub_valid(ptr_q)) begin
              oe_n_d = 1'b0;
              st_d = ST_ACK;
              nx_d = ST_WR;
              wr_d = 1'b1;
              wd_d = sh_q;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            st_d = nx_q;
            cnt_d = '0;
            oe_n_d = (nx_q == ST_RD) ? rd_data[7] : 1'b1;
            sh_d = {rd_data[6:0], 1'b0};
          end
        end
        ST_RD: begin
          if (fall && cnt_q == vme_pkg::BITS_LAST) begin
            oe_n_d = 1'b1;
            st_d = ST_MACK;
          end else if (fall) begin
            oe_n_d = sh_q[7];
            sh_d = {sh_q[6:0], 1'b0};
            cnt_d = 4'(cnt_q + 4'h1);
          end
        end
        ST_MACK: begin
          if (rise && sda_s) begin
            st_d = ST_IDLE;
          end else if (rise) begin
            st_d = ST_ACK;
            nx_d = ST_RD;
            if (ptr_q < vme_pkg::SUB_LAST) begin
              ptr_d = 8'(ptr_q + vme_pkg::SUB_STEP);
            end
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
    // pointer moves on once the byte has been written.
    if (wr_q) begin
      ptr_d = 8'(ptr_q + vme_pkg::SUB_STEP);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      nx_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      ptr_q <= vme_pkg::SUB_FIRST;
      wd_q <= '0;
      oe_n_q <= 1'b1;
      wr_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en) begin
      st_q <= st_d;
      nx_q <= nx_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      wd_q <= wd_d;
      oe_n_q <= oe_n_d;
      wr_q <= wr_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  assign reg_addr = ptr_q;
  assign wr_pulse = wr_q;
  assign wr_data = wd_q;
  assign sda_oe_n = oe_n_q;
endmodule

// File: dv/vme_host.sv
// Two-wire bus host model that programs and reads the mode bank.
`timescale 1ns/1ps
module vme_host (
  input wire logic sys_clk,
  input wire logic sda_i,
  output logic scl,
  output logic sda_o
);
  localparam logic [7:0] ADR_W = {vme_pkg::SLAVE_BASE | 7'h02, 1'b0};
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hp();
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic bt(input logic b, output logic r);
    sda_o <= b;
    hp();
    scl <= 1'b1;
    hp();
    r = sda_i;
    scl <= 1'b0;
    hp();
  endtask
  task automatic st();
    sda_o <= 1'b1;
    hp();
    scl <= 1'b1;
    hp();
    sda_o <= 1'b0;
    hp();
    scl <= 1'b0;
    hp();
  endtask
  task automatic sp();
    sda_o <= 1'b0;
    hp();
    scl <= 1'b1;
    hp();
    sda_o <= 1'b1;
    hp();
  endtask
  task automatic xb(input logic [7:0] b, output logic [7:0] q,
                    output logic nak);
    for (int i = 7; i >= 0; i--) bt(b[i], q[i]);
    bt(1'b1, nak);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [23:0] d,
                    input int n, output logic nak);
    logic [7:0] q;
    logic k;
    st();
    xb(ADR_W, q, nak);
    xb(sub, q, k);
    nak = nak | k;
    for (int i = 0; i < n; i++) begin
      xb(d[23-8*i -: 8], q, k);
      nak = nak | k;
    end
    sp();
  endtask
  // repeated start read, ended by no-acknowledge
  task automatic rd(input logic [7:0] sub, output logic [7:0] q);
    logic k;
    st();
    xb(ADR_W, q, k);
    xb(sub, q, k);
    st();
    xb(ADR_W | 8'h01, q, k);
    xb(8'hff, q, k);
    sp();
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the mode bank driven over the two-wire bus.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, rstn, sp, pu, gp, osl, stm, tbr, scl, sda_o, oe_n, nak;
  logic yuv, pal, blank, fmt, slp, tt, fs, ped, sq, th, rte, scr, vbp, tti;
  logic ttr, lvs, cho, bur, cb, il, ysm, rgs, cln, clb;
  logic [1:0] ccf, cls;
  logic [3:0] vhl;
  logic [7:0] q;
  logic [9:0] px, uv;
  vme_pkg::vme_dac_src_t da, db, dc, dd, de, df;
  int miscompares = 0;
  int n_tests = 0;
  wire sda = sda_o & oe_n;
  vme_host h (.sys_clk(sys_clk), .sda_i(sda), .scl(scl), .sda_o(sda_o));
  vme_mode_bank u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1),
    .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(), .sda_pin_oe_n(oe_n),
    .addr_lsb_pin(1'b1), .standard_select_pin(sp), .genlock_pin(gp),
    .teletext_input_pin(tt), .output_standard_low_bit(osl),
    .slave_timing_mode(stm), .oversample_4x(1'b0),
    .power_up_sleep_control(pu), .field_start(fs),
    .teletext_bit_request(tbr), .dac_a_src(da), .dac_b_src(db),
    .dac_c_src(dc), .dac_d_src(dd), .dac_e_src(de), .dac_f_src(df),
    .component_yuv(yuv), .std_pal(pal), .pedestal_active(ped),
    .square_pixel_active(sq), .pixel_blank(blank),
    .force_master_timing(fmt), .sleep_active(slp),
    .blanking_interval_pass(vbp), .teletext_insert(tti),
    .teletext_request(ttr), .long_vertical_sync(lvs),
    .vsync_half_lines(vhl), .timing_hold(th), .subcarrier_reset(scr),
    .rtc_enable(rte), .rtc_data(), .active_line_pixels(px),
    .chroma_on(cho), .burst_on(bur), .color_bars_on(cb),
    .interlace_ctl(il), .cc_field_select(ccf), .y_smpte_levels(ysm),
    .uv_amp_mv(uv), .rgb_sync_on(rgs), .clamp_shift(cls),
    .clamp_negative(cln), .clamp_back_porch(clb));
  task automatic chk(input string nm, input logic [17:0] e,
                     input logic [17:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // the bench clock stands in for the square pixel clock.
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    {rstn, sp, pu, gp, osl, stm, tbr, tt, fs} = '0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("blank", 18'h3, {blank, fmt});
    chk("pixels", vme_pkg::PIX_601, px);
    for (int i = 0; i < 8; i++) begin
      h.wr(8'h02, {i[7:0], 16'h0}, 1, nak);
      chk("dacs", i[1] ? 18'h014e5 : i[2] ? 18'h04aca : 18'h1ca0a,
          {da, db, dc, dd, de, df});
      chk("yuv", i[0], yuv);
    end
    sp <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("pin std", 18'h1, pal);
    h.wr(8'h02, 24'h380000, 1, nak);
    chk("reg std", 18'h0, pal);
    chk("ped sq", 18'h2, {ped, sq});
    stm <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("ped sq", 18'h3, {ped, sq});
    tt <= 1'b1;
    h.wr(8'h03, 24'h7c79db, 3, nak);
    chk("ack", 18'h0, nak);
    chk("pixels", vme_pkg::PIX_NTSC_470, px);
    chk("uv", vme_pkg::MV_700, uv);
    chk("teletext", 18'h1b, {vbp, tti, ttr, ccf});
    chk("sync", 18'h2dc, {lvs, vhl, cho, bur, cb, il, th});
    chk("clamp", 18'h37, {ysm, rgs, cls, cln, clb});
    h.rd(8'h03, q);
    chk("rev", 18'h7d, q);
    h.wr(8'h06, 24'h0, 0, nak);
    chk("bad sub", 18'h1, nak);
    h.wr(8'h02, 24'hc00000, 1, nak);
    chk("sleep", 18'h2, {slp, blank});
    rstn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("reset sleep", 18'h1, {slp, blank});
    h.wr(8'h04, 24'h020000, 1, nak);
    gp <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fs <= 1'b1;
    @(posedge sys_clk);
    fs <= 1'b0;
    @(posedge sys_clk);
    chk("sc reset", 18'h1, scr);
    h.wr(8'h04, 24'h040000, 1, nak);
    chk("hold", 18'h2, {th, rte});
    pu <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("pin sleep", 18'h1, slp);
    wrap_up();
  end
endmodule
